//--- verilog/bcpm_port.sv
// port f pin mux with its register file behind an ahb-lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
// How it works
// - direction loads 80 or 00 by mode
// - direction reads back a fixed value
// - output latch read/write, clears on reset
// - pin state: latch if output, else pin
// - pin state ignores writes
// - function control resets 30, low bits zero
// - wait select bit picks pin 2 or alternate
// - bus request select picks pin 2 or alternate
// - pin 6 address strobe in bus modes unless disabled
// - pin 3 low write in bus modes unless disabled
// - pin 7 outputs clock when direction set
// - pin 5 read strobe in bus modes
// - pin 4 high write in bus modes
// - pin 2 column strobe, request, wait or io
// - pin 1 bus grant when release enabled
// - pin 0 bus request input when enabled
// - system control resets to 01
// - standby holds or floats bus pins
// - pin state reflects pins, frozen in standby
module bcpm_port #(
  parameter int PIN_COUNT = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [2:0]           op_mode,
  input  wire logic                 hw_standby,
  input  wire logic                 sw_standby,
  input  wire logic                 sys_clk_level,
  input  wire bcpm_pkg::bcpm_bc_type bc_sig,
  output logic                      wait_n_to_bc,
  output logic                      external_bus_request_in_n_to_bc,
  output logic                      wait_pin_select,
  output logic                      bus_request_out_pin_select,
  input  wire logic [7:0]           pin_in,
  output logic      [7:0]           pin_out,
  output logic      [7:0]           pin_oe
);
  import bcpm_pkg::*;

  // the pin functions are fixed to an eight-pin port
  if (PIN_COUNT != 8) begin : g_bad_width
    $error("bcpm_port serves exactly eight pins");
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic [7:0]      dir_r;
  logic [7:0]      latch_r;
  logic [7:0]      port_function_control_two_r;
  logic [7:0]      sysctl_r;
  logic [7:0]      buscfg_r;
  logic            init_pend_r;
  logic [7:0]      snap_r;
  logic [7:0]      hold_out_r;
  logic [7:0]      hold_oe_r;
  bcpm_dphase_type dph_r;
  logic            ext_mode;
  logic            wr_en;
  logic [7:0]      wdat;
  logic [7:0]      pin_view;
  logic [7:0]      func_mask;
  logic [7:0]      mux_out;
  logic [7:0]      mux_oe;
  logic            low_column_strobe_here;
  logic            bus_request_output_here;
  logic            wait_here;
  logic            bus_release_enable_on;

  assign ext_mode = (op_mode != MODE_SINGLE);
  assign wait_pin_select = port_function_control_two_r[WAIT_PIN_SEL_BIT];
  assign bus_request_out_pin_select = port_function_control_two_r[BUS_REQUEST_OUTPUT_PIN_SEL_BIT];

  // ----------------------------------------------------------
  // ahb-lite slave, zero wait states, always okay
  // ----------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase captured for the following data phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dph_r <= '0;
    end else if (hready) begin
      dph_r.act   <= hsel && (htrans == HTRANS_NONSEQ);
      dph_r.write <= hwrite;
      dph_r.idx   <= haddr[17:2];
    end
  end

  assign wr_en = dph_r.act && dph_r.write && hready;
  assign wdat  = hwdata[7:0];

  // mode-dependent load happens after release, never at reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      init_pend_r <= 1'b1;
    end else begin
      init_pend_r <= 1'b0;
    end
  end

  // direction: mode default on init, kept in software standby
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dir_r <= DIR_RST_MODE7;
    end else if (init_pend_r || hw_standby) begin
      dir_r <= ext_mode ? DIR_RST_EXT : DIR_RST_MODE7;
    end else if (wr_en && dph_r.idx == IDX_DIR) begin
      dir_r <= wdat;
    end
  end

  // output latch; pin-state writes never land here
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r <= LATCH_RST;
    end else if (hw_standby) begin
      latch_r <= LATCH_RST;
    end else if (wr_en && dph_r.idx == IDX_LATCH) begin
      latch_r <= wdat;
    end
  end

  // function control; reserved low bits stay zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port_function_control_two_r <= PORT_FUNCTION_CONTROL_TWO_RST;
    end else if (hw_standby) begin
      port_function_control_two_r <= PORT_FUNCTION_CONTROL_TWO_RST;
    end else if (wr_en && dph_r.idx == IDX_PORT_FUNCTION_CONTROL_TWO) begin
      port_function_control_two_r <= wdat & PORT_FUNCTION_CONTROL_TWO_WMASK;
    end
  end

  // system control; not touched by software standby
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sysctl_r <= SYSCTL_RST;
    end else if (hw_standby) begin
      sysctl_r <= SYSCTL_RST;
    end else if (wr_en && dph_r.idx == IDX_SYSCTL) begin
      sysctl_r <= wdat & SYSCTL_WMASK;
    end
  end

  // bus controller and standby bits used by the mux
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buscfg_r <= BUSCFG_RST;
    end else if (hw_standby) begin
      buscfg_r <= BUSCFG_RST;
    end else if (wr_en && dph_r.idx == IDX_BUSCFG) begin
      buscfg_r <= wdat & BUSCFG_WMASK;
    end
  end

  // ----------------------------------------------------------
  // pin state view
  // ----------------------------------------------------------
  // outputs read back the latch, inputs the live pin
  assign pin_view = (dir_r & latch_r) | (~dir_r & pin_in);

  // snapshot frozen while in software standby
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      snap_r <= 8'h00;
    end else if (!sw_standby) begin
      snap_r <= pin_view;
    end
  end

  // read mux; direction never exposes its contents
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dph_r.act && !dph_r.write) begin
      unique case (dph_r.idx)
        IDX_DIR:      hrdata[7:0] = DIR_READ_VAL;
        IDX_LATCH:    hrdata[7:0] = latch_r;
        IDX_PINSTATE: hrdata[7:0] = sw_standby ? snap_r : pin_view;
        IDX_PORT_FUNCTION_CONTROL_TWO:    hrdata[7:0] = port_function_control_two_r;
        IDX_SYSCTL:   hrdata[7:0] = sysctl_r;
        IDX_BUSCFG:   hrdata[7:0] = buscfg_r;
        default:      hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------
  // pin 2 priority: column strobe, request out, wait, io
  assign low_column_strobe_here  = ext_mode && buscfg_r[DRAM16_BIT];
  assign bus_request_output_here = ext_mode && !low_column_strobe_here && buscfg_r[BUS_REQUEST_OUT_ENABLE_BIT]
                      && !port_function_control_two_r[BUS_REQUEST_OUTPUT_PIN_SEL_BIT];
  assign wait_here  = ext_mode && !low_column_strobe_here && !bus_request_output_here
                      && buscfg_r[WAIT_INPUT_ENABLE_BIT]
                      && !port_function_control_two_r[WAIT_PIN_SEL_BIT];
  assign bus_release_enable_on    = ext_mode && buscfg_r[BUS_RELEASE_ENABLE_BIT];

  // wait pin with direction set is a prohibited setup; pin still read
  assign wait_n_to_bc = wait_here ? pin_in[2] : 1'b1;
  assign external_bus_request_in_n_to_bc = bus_release_enable_on ? pin_in[0] : 1'b1;

  // per-pin value and enable, purely from current settings
  always_comb begin
    mux_out   = latch_r;
    mux_oe    = dir_r;
    func_mask = 8'h00;
    // pin 7: clock out in every mode
    mux_out[7] = sys_clk_level;
    func_mask[7] = dir_r[7];
    // pin 6: address strobe
    if (ext_mode && !port_function_control_two_r[AS_DISABLE_BIT]) begin
      mux_out[6]   = bc_sig.as_n;
      mux_oe[6]    = 1'b1;
      func_mask[6] = 1'b1;
    end
    // pin 5 and 4: read and high write strobes
    if (ext_mode) begin
      mux_out[5]   = bc_sig.rd_n;
      mux_oe[5]    = 1'b1;
      func_mask[5] = 1'b1;
      mux_out[4]   = bc_sig.hwr_n;
      mux_oe[4]    = 1'b1;
      func_mask[4] = 1'b1;
    end
    // pin 3: low write strobe
    if (ext_mode && !sysctl_r[LWR_DISABLE_BIT]) begin
      mux_out[3]   = bc_sig.lwr_n;
      mux_oe[3]    = 1'b1;
      func_mask[3] = 1'b1;
    end
    // pin 2: shared strobe, request and wait
    if (low_column_strobe_here) begin
      mux_out[2]   = bc_sig.low_column_strobe_n;
      mux_oe[2]    = 1'b1;
      func_mask[2] = 1'b1;
    end else if (bus_request_output_here) begin
      mux_out[2]   = bc_sig.bus_request_output_n;
      mux_oe[2]    = 1'b1;
      func_mask[2] = 1'b1;
    end else if (wait_here) begin
      mux_oe[2]    = 1'b0;
    end
    // pins 1 and 0: bus release handshake
    if (bus_release_enable_on) begin
      mux_out[1]   = bc_sig.back_n;
      mux_oe[1]    = 1'b1;
      func_mask[1] = 1'b1;
      mux_oe[0]    = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // software standby
  // ----------------------------------------------------------
  // capture drive state up to entry so it can be held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_out_r <= 8'h00;
      hold_oe_r  <= 8'h00;
    end else if (!sw_standby) begin
      hold_out_r <= mux_out;
      hold_oe_r  <= mux_oe;
    end
  end

  // bus pins hold or float; plain io pins keep driving
  always_comb begin
    pin_out = mux_out;
    pin_oe  = mux_oe;
    if (sw_standby) begin
      for (int i = 0; i < 8; i++) begin
        if (func_mask[i]) begin
          pin_out[i] = hold_out_r[i];
          pin_oe[i]  = hold_oe_r[i] && buscfg_r[HOLD_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  property p_dir_init;
    @(posedge mclk) disable iff (!reset_n)
      hw_standby |=> dir_r == ($past(ext_mode) ? DIR_RST_EXT : DIR_RST_MODE7);
  endproperty
  a_dir_init: assert property (p_dir_init)
    else $error("direction not loaded by mode");

  property p_dir_read;
    @(posedge mclk) disable iff (!reset_n)
      (dph_r.act && !dph_r.write && dph_r.idx == IDX_DIR)
        |-> hrdata[7:0] == DIR_READ_VAL;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read leaked contents");

  property p_latch_clr;
    @(posedge mclk) disable iff (!reset_n)
      hw_standby |=> latch_r == LATCH_RST;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch not cleared");

  property p_pin_read;
    @(posedge mclk) disable iff (!reset_n)
      (dph_r.act && !dph_r.write && dph_r.idx == IDX_PINSTATE && !sw_standby)
        |-> hrdata[7:0] == ((dir_r & latch_r) | (~dir_r & pin_in));
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin state read wrong");

  property p_pin_nowrite;
    @(posedge mclk) disable iff (!reset_n)
      (wr_en && dph_r.idx == IDX_PINSTATE && !hw_standby) |=> $stable(latch_r);
  endproperty
  a_pin_nowrite: assert property (p_pin_nowrite)
    else $error("pin state write changed latch");

  property p_port_function_control_two_low;
    @(posedge mclk) disable iff (!reset_n)
      (dph_r.act && !dph_r.write && dph_r.idx == IDX_PORT_FUNCTION_CONTROL_TWO) |-> hrdata[2:0] == 3'h0;
  endproperty
  a_port_function_control_two_low: assert property (p_port_function_control_two_low)
    else $error("reserved bits not zero");

  property p_as_pin;
    @(posedge mclk) disable iff (!reset_n)
      (ext_mode && !port_function_control_two_r[AS_DISABLE_BIT] && !sw_standby)
        |-> pin_oe[6] && pin_out[6] == bc_sig.as_n;
  endproperty
  a_as_pin: assert property (p_as_pin)
    else $error("address strobe not on pin 6");

  property p_clk_pin;
    @(posedge mclk) disable iff (!reset_n)
      !sw_standby |-> pin_oe[7] == dir_r[7] && pin_out[7] == sys_clk_level;
  endproperty
  a_clk_pin: assert property (p_clk_pin)
    else $error("clock pin wrong");

  property p_sysctl_init;
    @(posedge mclk) disable iff (!reset_n)
      hw_standby |=> sysctl_r == SYSCTL_RST;
  endproperty
  a_sysctl_init: assert property (p_sysctl_init)
    else $error("system control not reset");

  property p_float;
    @(posedge mclk) disable iff (!reset_n)
      (sw_standby && ext_mode && !buscfg_r[HOLD_BIT]) |-> !pin_oe[5] && !pin_oe[4];
  endproperty
  a_float: assert property (p_float)
    else $error("strobe pins not floated");

  property p_snap;
    @(posedge mclk) disable iff (!reset_n)
      sw_standby [*2] |-> $stable(snap_r);
  endproperty
  a_snap: assert property (p_snap)
    else $error("pin snapshot moved in standby");

endmodule

//--- verilog/bcpm_pkg.sv
// shared constants and types for the bus control port mux
package bcpm_pkg;
  // ----------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------
  localparam logic [15:0] IDX_DIR      = 16'hFEBE;
  localparam logic [15:0] IDX_SYSCTL   = 16'hFF39;
  localparam logic [15:0] IDX_PINSTATE = 16'hFF5E;
  localparam logic [15:0] IDX_LATCH    = 16'hFF6E;
  localparam logic [15:0] IDX_PORT_FUNCTION_CONTROL_TWO    = 16'hFFAC;
  localparam logic [15:0] IDX_BUSCFG   = 16'h0010;
  // ----------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------
  localparam logic [7:0] DIR_RST_EXT   = 8'h80;
  localparam logic [7:0] DIR_RST_MODE7 = 8'h00;
  localparam logic [7:0] DIR_READ_VAL  = 8'h00;
  localparam logic [7:0] LATCH_RST     = 8'h00;
  localparam logic [7:0] PORT_FUNCTION_CONTROL_TWO_RST     = 8'h30;
  localparam logic [7:0] PORT_FUNCTION_CONTROL_TWO_WMASK   = 8'hF8;
  localparam logic [7:0] SYSCTL_RST    = 8'h01;
  localparam logic [7:0] SYSCTL_WMASK  = 8'hBF;
  localparam logic [7:0] BUSCFG_RST    = 8'h00;
  localparam logic [7:0] BUSCFG_WMASK  = 8'h1F;
  localparam logic [2:0] MODE_SINGLE   = 3'h7;
  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int WAIT_PIN_SEL_BIT  = 7;
  localparam int BUS_REQUEST_OUTPUT_PIN_SEL_BIT = 6;
  localparam int AS_DISABLE_BIT    = 3;
  localparam int LWR_DISABLE_BIT   = 2;
  localparam int HOLD_BIT          = 0;
  localparam int BUS_RELEASE_ENABLE_BIT          = 1;
  localparam int BUS_REQUEST_OUT_ENABLE_BIT        = 2;
  localparam int WAIT_INPUT_ENABLE_BIT         = 3;
  localparam int DRAM16_BIT        = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // strobes and requests from the bus controller, all active low
  typedef struct packed {
    logic as_n;
    logic rd_n;
    logic hwr_n;
    logic lwr_n;
    logic low_column_strobe_n;
    logic bus_request_output_n;
    logic back_n;
  } bcpm_bc_type;
  // data-phase bookkeeping of the bus slave
  typedef struct packed {
    logic        act;
    logic        write;
    logic [15:0] idx;
  } bcpm_dphase_type;
endpackage

//--- sim/bcpm_pins.sv
// far-side model of the port pins: pull-ups plus a bench-driven source
`timescale 1ns/1ps
module bcpm_pins (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_lvl
);
  // ----------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------
  // device drive wins; outside parts only drive a released pin, else pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i] === 1'b1) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i] === 1'b1) begin
        pin_lvl[i] = ext_val[i];
      end else begin
        pin_lvl[i] = 1'b1;
      end
    end
  end
endmodule

//--- sim/bus_control_port_mux_tb_top.sv
// self-checking bench for the bus control port mux
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module bus_control_port_mux_tb_top;
  import bcpm_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n, hsel, hwrite, hw_standby, sw_standby, sys_clk_level;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, op_mode;
  logic        hreadyout, hresp, wait_n_to_bc, external_bus_request_in_n_to_bc, wsel, bsel;
  logic [7:0]  pin_in, pin_out, pin_oe, ext_val, ext_en;
  bcpm_bc_type bc;
  int          err_count = 0;
  int          checked = 0;

  always #10 mclk = ~mclk;

  bcpm_port bcpm_port_i (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .op_mode(op_mode),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .sys_clk_level(sys_clk_level),
    .bc_sig(bc), .wait_n_to_bc(wait_n_to_bc), .external_bus_request_in_n_to_bc(external_bus_request_in_n_to_bc),
    .wait_pin_select(wsel), .bus_request_out_pin_select(bsel), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  bcpm_pins bcpm_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_lvl(pin_in));

  // ----------------------------------------------------------
  // closing report
  // ----------------------------------------------------------
  task results;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // ahb-lite master
  // ----------------------------------------------------------
  // bounded wait for hready at a rising edge; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      results();
    end
  endtask

  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, idx, d, x);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] x;
    xfer(1'b0, idx, 8'h00, x);
    `CHK(x, e)
  endtask

  // pin drive checked only where the device drives
  task automatic pchk(input logic [7:0] oe, input logic [7:0] out);
    @(negedge mclk);
    `CHK(pin_oe, oe)
    `CHK(pin_out & pin_oe, out)
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    // direction takes its mode default one edge after release
    @(posedge mclk);
    pchk(8'hF8, 8'hA0);
    rdc(IDX_LATCH, LATCH_RST);
    rdc(IDX_PORT_FUNCTION_CONTROL_TWO, PORT_FUNCTION_CONTROL_TWO_RST);
    rdc(IDX_SYSCTL, SYSCTL_RST);
    rdc(IDX_DIR, DIR_READ_VAL);
    rdc(IDX_PINSTATE, {1'b0, bc.as_n, bc.rd_n, bc.hwr_n, bc.lwr_n, ext_val[2:0]});
    `CHK(hresp, 1'b0)
  endtask

  // reserved bits, read-only and unmapped places
  task automatic t_regs;
    wr(IDX_LATCH, 8'h5A);
    wr(IDX_PINSTATE, 8'h00);
    rdc(IDX_LATCH, 8'h5A);
    wr(IDX_PORT_FUNCTION_CONTROL_TWO, 8'hFF);
    rdc(IDX_PORT_FUNCTION_CONTROL_TWO, 8'hF8);
    wr(IDX_DIR, 8'hFB);
    rdc(IDX_DIR, DIR_READ_VAL);
    rdc(16'h0123, 8'h00);
    wr(IDX_PORT_FUNCTION_CONTROL_TWO, 8'h00);
  endtask

  // expanded-mode pin functions, one select at a time
  task automatic t_bus_pins;
    pchk(8'hFB, 8'hA2);
    `CHK(external_bus_request_in_n_to_bc, 1'b1)
    wr(IDX_PORT_FUNCTION_CONTROL_TWO, 8'h08);
    wr(IDX_SYSCTL, 8'h05);
    wr(IDX_BUSCFG, 8'h02);
    pchk(8'hFA, 8'hE8);
    `CHK(external_bus_request_in_n_to_bc, ext_val[0])
    wr(IDX_BUSCFG, 8'h04);
    pchk(8'hFF, 8'hEE);
    `CHK(bsel, 1'b0)
    wr(IDX_PORT_FUNCTION_CONTROL_TWO, 8'h48);
    pchk(8'hFB, 8'hEA);
    `CHK(bsel, 1'b1)
    wr(IDX_PORT_FUNCTION_CONTROL_TWO, 8'h08);
    wr(IDX_BUSCFG, 8'h08);
    pchk(8'hFB, 8'hEA);
    `CHK(wait_n_to_bc, ext_val[2])
    wr(IDX_PORT_FUNCTION_CONTROL_TWO, 8'h88);
    @(negedge mclk);
    `CHK(wait_n_to_bc, 1'b1)
    `CHK(wsel, 1'b1)
    wr(IDX_BUSCFG, 8'h10);
    pchk(8'hFF, 8'hEE);
  endtask

  // single-chip mode: general purpose except the pin 7 clock
  task automatic t_mode7;
    @(posedge mclk);
    op_mode <= MODE_SINGLE;
    pchk(8'hFB, 8'hDA);
    rdc(IDX_PINSTATE, 8'h5A);
    @(posedge mclk);
    sys_clk_level <= 1'b0;
    pchk(8'hFB, 8'h5A);
    // hardware standby in single-chip mode loads direction 00
    @(posedge mclk);
    hw_standby <= 1'b1;
    @(posedge mclk);
    hw_standby <= 1'b0;
    pchk(8'h00, 8'h00);
  endtask

  task automatic t_hw_standby;
    @(posedge mclk);
    op_mode <= 3'h5;
    hw_standby <= 1'b1;
    repeat (2) @(posedge mclk);
    hw_standby <= 1'b0;
    pchk(8'hF8, 8'h20);
    rdc(IDX_LATCH, LATCH_RST);
    rdc(IDX_PORT_FUNCTION_CONTROL_TWO, PORT_FUNCTION_CONTROL_TWO_RST);
    rdc(IDX_SYSCTL, SYSCTL_RST);
  endtask

  // bus pins hold or float by the hold bit; registers and pin state kept
  task automatic t_sw_standby;
    wr(IDX_SYSCTL, 8'h05);
    wr(IDX_BUSCFG, 8'h01);
    wr(IDX_LATCH, 8'h3C);
    @(posedge mclk);
    sw_standby <= 1'b1;
    @(posedge mclk);
    bc.rd_n <= 1'b0;
    ext_val <= 8'hA5;
    pchk(8'hF0, 8'h20);
    rdc(IDX_PINSTATE, 8'h2A);
    rdc(IDX_LATCH, 8'h3C);
    @(posedge mclk);
    sw_standby <= 1'b0;
    wr(IDX_BUSCFG, 8'h00);
    @(posedge mclk);
    sw_standby <= 1'b1;
    pchk(8'h00, 8'h00);
    rdc(IDX_SYSCTL, 8'h05);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {hsel, hwrite, hw_standby, sw_standby} = 4'h0;
    sys_clk_level = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    op_mode = 3'h4;
    bc = 7'b0100110;
    ext_val = 8'h5A;
    ext_en = 8'hFF;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_bus_pins();
    t_mode7();
    t_hw_standby();
    t_sw_standby();
    results();
  end
endmodule
